// ---- bxc_exec.sv ----
`timescale 1ns/10ps
module bxc_exec
   import bxc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic [7:0] sw_addr,
   input  wire logic [7:0] sw_wdata,
   input  wire logic       sw_wr,
   input  wire logic       sw_rd,
   output logic      [7:0] sw_rdata,
   output bxc_mem_t        pm_req,
   input  wire logic [7:0] pm_rdata,
   output bxc_mem_t        rf_req,
   input  wire logic [7:0] rf_rdata,
   output bxc_mem_t        st_req,
   input  wire logic [7:0] st_rdata,
   output logic            busy
);

   function automatic logic [3:0] op_len(input logic [7:0] op);
      case (op)
         OP_BIT_EXCLUSIVE_OR_OP:     op_len = CYC_BIT_EXCLUSIVE_OR_OP;
         OP_CALL_DA:  op_len = CYC_CALL_DA;
         OP_CALL_IRR: op_len = CYC_CALL_IRR;
         OP_CALL_IA:  op_len = CYC_CALL_IA;
         OP_CCF:      op_len = CYC_CCF;
         OP_CLR_R:    op_len = CYC_CLR;
         OP_CLR_IR:   op_len = CYC_CLR;
         OP_RET:      op_len = CYC_RET;
         default:     op_len = CYC_OTHER;
      endcase
   endfunction

   // working register n inside the current working bank
   function automatic logic [7:0] wreg(input logic [7:0] base,
                                       input logic [3:0] n);
      wreg = {base[7:4], n};
   endfunction

   // the flags byte is served here, not by the register file
   function automatic logic is_flags(input logic [7:0] a);
      is_flags = (a == OFF_FLAGS);
   endfunction

   bxc_regs_t   q;         // registered state
   bxc_regs_t   d;         // next state
   logic [7:0]  rdv;       // register read data after flags mux
   logic        rd_go;     // register read request
   logic [7:0]  rd_a;      // register read address
   logic        wr_go;     // register write request
   logic [7:0]  wr_a;      // register write address
   logic [7:0]  wr_v;      // register write data
   logic        bx_go;     // bit xor result valid
   logic        bx_res;    // bit xor result bit
   logic [2:0]  bsel;      // selected bit position
   logic [7:0]  nv;        // modified byte for bit xor
   logic        done;      // instruction budget used up
   bxc_state_t  fin;       // where a finishing step goes
   logic [15:0] pc_nx;     // pc after consuming a byte

   assign sw_rdata = q.rdata;
   assign busy     = (q.st != ST_IDLE);

   // sequencer and register access
   always_comb begin
      d      = q;
      pm_req = '0;
      rf_req = '0;
      st_req = '0;
      rd_go  = 1'b0;
      rd_a   = 8'h00;
      wr_go  = 1'b0;
      wr_a   = 8'h00;
      wr_v   = 8'h00;
      bx_go  = 1'b0;
      bx_res = 1'b0;
      nv     = 8'h00;
      bsel   = q.b2[3:1];
      pc_nx  = q.pc + 16'h0001;
      rdv    = q.rd_fl ? q.flags : rf_rdata;
      done   = (q.cnt >= (q.len - 4'h1));
      fin    = done ? (q.run ? ST_FETCH : ST_IDLE) : ST_WAIT;
      d.rd_fl = 1'b0;
      d.rdata = 8'h00;
      d.cnt   = q.cnt + 4'h1;

      // software reads: data stands one cycle later only
      if (sw_rd) begin
         case (sw_addr)
            OFF_CTRL:  d.rdata = {7'h00, q.run};
            OFF_STAT:  d.rdata = {7'h00, busy};
            OFF_PCH:   d.rdata = q.pc[15:8];
            OFF_PCL:   d.rdata = q.pc[7:0];
            OFF_FLAGS: d.rdata = q.flags;
            OFF_WBASE: d.rdata = q.wbase;
            OFF_SPH:   d.rdata = q.sp[15:8];
            OFF_SPL:   d.rdata = q.sp[7:0];
            default:   d.rdata = 8'h00;
         endcase
      end

      // software writes; the core's own updates below win
      if (sw_wr) begin
         case (sw_addr)
            OFF_CTRL:  d.run = sw_wdata[0];
            OFF_FLAGS: d.flags = sw_wdata;
            OFF_WBASE: d.wbase = sw_wdata;
            OFF_SPH:   d.sp[15:8] = sw_wdata;
            OFF_SPL:   d.sp[7:0] = sw_wdata;
            // pc only moves while stopped, a live pc would tear
            OFF_PCH:   if (!busy) d.pc[15:8] = sw_wdata;
            OFF_PCL:   if (!busy) d.pc[7:0] = sw_wdata;
            default:   ;
         endcase
      end

      case (q.st)
         // stopped, waiting for run
         ST_IDLE: begin
            if (q.run) d.st = ST_FETCH;
         end
         // cycle 0: ask for the opcode
         ST_FETCH: begin
            pm_req.addr = q.pc;
            pm_req.rd   = 1'b1;
            d.cnt       = 4'h1;
            d.st        = ST_OPC;
         end
         // cycle 1: opcode arrives
         ST_OPC: begin
            d.op  = pm_rdata;
            d.pc  = pc_nx;
            d.len = op_len(pm_rdata);
            case (pm_rdata)
               OP_CCF: begin
                  d.flags[FL_C] = ~q.flags[FL_C];
                  d.st = ST_WAIT;
               end
               OP_RET:  d.st = ST_POP1;
               OP_BIT_EXCLUSIVE_OR_OP, OP_CALL_DA, OP_CALL_IRR, OP_CALL_IA,
               OP_CLR_R, OP_CLR_IR: begin
                  pm_req.addr = pc_nx;
                  pm_req.rd   = 1'b1;
                  d.st        = ST_B2;
               end
               // anything else is a one-byte no-op here
               default: d.st = ST_WAIT;
            endcase
         end
         // second byte arrives
         ST_B2: begin
            d.b2 = pm_rdata;
            d.pc = pc_nx;
            case (q.op)
               OP_BIT_EXCLUSIVE_OR_OP, OP_CALL_DA: begin
                  pm_req.addr = pc_nx;
                  pm_req.rd   = 1'b1;
                  d.st        = ST_B3;
               end
               OP_CALL_IRR: begin
                  rd_go = 1'b1;
                  rd_a  = pm_rdata;
                  d.st  = ST_R2;
               end
               OP_CALL_IA: begin
                  pm_req.addr = {8'h00, pm_rdata};
                  pm_req.rd   = 1'b1;
                  d.st        = ST_R2;
               end
               OP_CLR_R: begin
                  wr_go = 1'b1;
                  wr_a  = pm_rdata;
                  wr_v  = 8'h00;
                  d.st  = fin;
               end
               OP_CLR_IR: begin
                  rd_go = 1'b1;
                  rd_a  = pm_rdata;
                  d.st  = ST_R2;
               end
               default: d.st = fin;
            endcase
         end
         // third byte arrives
         ST_B3: begin
            d.b3 = pm_rdata;
            d.pc = pc_nx;
            if (q.op == OP_CALL_DA) begin
               d.tgt = {q.b2, pm_rdata};
               d.st  = ST_PUSH1;
            end else begin
               rd_go = 1'b1;
               rd_a  = wreg(q.wbase, q.b2[7:4]);
               d.st  = ST_R2;
            end
         end
         // first operand arrives
         ST_R2: begin
            case (q.op)
               OP_CALL_IRR: begin
                  d.tgt[15:8] = rdv;
                  rd_go = 1'b1;
                  rd_a  = q.b2 + 8'h01;
                  d.st  = ST_R3;
               end
               OP_CALL_IA: begin
                  d.tgt[15:8] = pm_rdata;
                  pm_req.addr = {8'h00, q.b2 + 8'h01};
                  pm_req.rd   = 1'b1;
                  d.st        = ST_R3;
               end
               OP_CLR_IR: begin
                  wr_go = 1'b1;
                  wr_a  = rdv;
                  wr_v  = 8'h00;
                  d.st  = fin;
               end
               default: begin
                  d.wv  = rdv;
                  rd_go = 1'b1;
                  rd_a  = q.b3;
                  d.st  = ST_R3;
               end
            endcase
         end
         // second operand arrives
         ST_R3: begin
            case (q.op)
               OP_CALL_IRR: begin
                  d.tgt[7:0] = rdv;
                  d.st       = ST_PUSH1;
               end
               OP_CALL_IA: begin
                  d.tgt[7:0] = pm_rdata;
                  d.st       = ST_PUSH1;
               end
               default: begin
                  bx_go = 1'b1;
                  if (!q.b2[0]) begin
                     bx_res = q.wv[0] ^ rdv[bsel];
                     nv     = {q.wv[7:1], bx_res};
                     wr_a   = wreg(q.wbase, q.b2[7:4]);
                  end else begin
                     bx_res     = rdv[bsel] ^ q.wv[0];
                     nv         = rdv;
                     nv[bsel]   = bx_res;
                     wr_a       = q.b3;
                  end
                  wr_go = 1'b1;
                  wr_v  = nv;
                  d.st  = fin;
               end
            endcase
         end
         // pc already points past the call
         ST_PUSH1: begin
            d.sp          = q.sp - 16'h0001;
            st_req.addr   = d.sp;
            st_req.wr     = 1'b1;
            st_req.wdata  = q.pc[7:0];
            d.st          = ST_PUSH2;
         end
         ST_PUSH2: begin
            d.sp          = q.sp - 16'h0001;
            st_req.addr   = d.sp;
            st_req.wr     = 1'b1;
            st_req.wdata  = q.pc[15:8];
            d.pc          = q.tgt;
            d.st          = fin;
         end
         ST_POP1: begin
            st_req.addr = q.sp;
            st_req.rd   = 1'b1;
            d.st        = ST_POP2;
         end
         ST_POP2: begin
            d.pc[15:8]  = st_rdata;
            d.sp        = q.sp + 16'h0001;
            st_req.addr = d.sp;
            st_req.rd   = 1'b1;
            d.st        = ST_POP3;
         end
         ST_POP3: begin
            d.pc[7:0] = st_rdata;
            d.sp      = q.sp + 16'h0001;
            d.st      = fin;
         end
         // pad out the instruction's cycle budget
         ST_WAIT: d.st = fin;
         default: d.st = ST_IDLE;
      endcase

      // register reads: flags are answered locally next cycle
      if (rd_go) begin
         if (is_flags(rd_a)) begin
            d.rd_fl = 1'b1;
         end else begin
            rf_req.addr = {8'h00, rd_a};
            rf_req.rd   = 1'b1;
         end
      end

      // register writes: flags byte is kept here
      // flags also change on ccf and bit xor, not only by a write to d5
      if (wr_go) begin
         if (is_flags(wr_a)) begin
            d.flags = wr_v;
         end else begin
            rf_req.addr  = {8'h00, wr_a};
            rf_req.wr    = 1'b1;
            rf_req.wdata = wr_v;
         end
      end

      // zero and sign after bit xor; v left as is
      if (bx_go) begin
         d.flags[FL_Z] = ~bx_res;
         d.flags[FL_S] = 1'b0;
      end
   end

   // state register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         q       <= '0;
         q.st    <= ST_IDLE;
         q.flags <= RST_FLAGS;
         q.wbase <= RST_WBASE;
         q.sp    <= RST_SP;
         q.pc    <= RST_PC;
      end else begin
         q <= d;
      end
   end

endmodule

// ---- bxc_pkg.sv ----
package bxc_pkg;

   // instruction encodings
   localparam logic [7:0] OP_BIT_EXCLUSIVE_OR_OP     = 8'h27;
   localparam logic [7:0] OP_CALL_DA  = 8'hf6;
   localparam logic [7:0] OP_CALL_IRR = 8'hf4;
   localparam logic [7:0] OP_CALL_IA  = 8'hd4;
   localparam logic [7:0] OP_CCF      = 8'hef;
   localparam logic [7:0] OP_CLR_R    = 8'hb0;
   localparam logic [7:0] OP_CLR_IR   = 8'hb1;
   localparam logic [7:0] OP_RET      = 8'haf;

   // cycles per instruction
   localparam logic [3:0] CYC_BIT_EXCLUSIVE_OR_OP     = 4'h6;
   localparam logic [3:0] CYC_CALL_DA  = 4'he;
   localparam logic [3:0] CYC_CALL_IRR = 4'hc;
   localparam logic [3:0] CYC_CALL_IA  = 4'he;
   localparam logic [3:0] CYC_CCF      = 4'h4;
   localparam logic [3:0] CYC_CLR      = 4'h4;
   localparam logic [3:0] CYC_RET      = 4'ha;
   localparam logic [3:0] CYC_OTHER    = 4'h4;

   // software register offsets
   localparam logic [7:0] OFF_CTRL  = 8'hd0;
   localparam logic [7:0] OFF_STAT  = 8'hd1;
   localparam logic [7:0] OFF_PCH   = 8'hd2;
   localparam logic [7:0] OFF_PCL   = 8'hd3;
   localparam logic [7:0] OFF_FLAGS = 8'hd5;
   localparam logic [7:0] OFF_WBASE = 8'hd6;
   localparam logic [7:0] OFF_SPH   = 8'hd8;
   localparam logic [7:0] OFF_SPL   = 8'hd9;

   // flag bit positions
   localparam int FL_C = 7;
   localparam int FL_Z = 6;
   localparam int FL_S = 5;
   localparam int FL_V = 4;
   localparam int FL_D = 3;
   localparam int FL_H = 2;

   // reset values
   localparam logic [7:0]  RST_FLAGS = 8'h00;
   localparam logic [7:0]  RST_WBASE = 8'hc0;
   localparam logic [15:0] RST_SP    = 16'h0000;
   localparam logic [15:0] RST_PC    = 16'h0000;

   // sequencer states
   typedef enum logic [3:0] {
      ST_IDLE, ST_FETCH, ST_OPC, ST_B2, ST_B3, ST_R2, ST_R3,
      ST_PUSH1, ST_PUSH2, ST_POP1, ST_POP2, ST_POP3, ST_WAIT
   } bxc_state_t;

   // one memory request (program, register file or stack)
   typedef struct packed {
      logic [15:0] addr;
      logic        rd;
      logic        wr;
      logic [7:0]  wdata;
   } bxc_mem_t;

   // whole state of the execution unit
   typedef struct packed {
      bxc_state_t  st;
      logic [15:0] pc;
      logic [15:0] sp;
      logic [15:0] tgt;
      logic [7:0]  op;
      logic [7:0]  b2;
      logic [7:0]  b3;
      logic [7:0]  wv;
      logic [7:0]  flags;
      logic [7:0]  wbase;
      logic [7:0]  rdata;
      logic [3:0]  cnt;
      logic [3:0]  len;
      logic        run;
      logic        rd_fl;
   } bxc_regs_t;

endpackage

// ---- bxc_exec_asserts.sv ----
`timescale 1ns/10ps
module bxc_exec_chk
   import bxc_pkg::*;
(
   input wire logic       clk,
   input wire logic       reset_n,
   input wire logic [7:0] sw_addr,
   input wire logic [7:0] sw_wdata,
   input wire logic       sw_wr,
   input wire logic       sw_rd,
   input wire logic [7:0] sw_rdata,
   input wire bxc_mem_t   pm_req,
   input wire logic [7:0] pm_rdata,
   input wire bxc_mem_t   rf_req,
   input wire logic [7:0] rf_rdata,
   input wire bxc_mem_t   st_req,
   input wire logic [7:0] st_rdata,
   input wire logic       busy
);
   // one clock domain, so one default clocking and reset
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   rdata_quiet_a : assert property (
      !$past(sw_rd) |-> sw_rdata == 8'h00) else $error("read data outside its cycle");
   flags_inside_a : assert property (
      (rf_req.rd || rf_req.wr) |-> rf_req.addr != 16'h00d5) else $error("flags sent out");
   rf_page_a : assert property (
      (rf_req.rd || rf_req.wr) |-> rf_req.addr[15:8] == 8'h00) else $error("rf high addr");
   pm_readonly_a : assert property (
      !pm_req.wr) else $error("program memory written");
   push_order_a : assert property (
      $rose(st_req.wr) |=> st_req.wr && st_req.addr == $past(st_req.addr) - 16'h0001
      ##1 !st_req.wr) else $error("push pair order");
   pop_order_a : assert property (
      $rose(st_req.rd) |=> st_req.rd && st_req.addr == $past(st_req.addr) + 16'h0001
      ##1 !st_req.rd) else $error("pop pair order");
   idle_quiet_a : assert property (
      !busy |-> !(pm_req.rd || rf_req.wr || st_req.wr)) else $error("request while idle");
   stack_single_a : assert property (
      !(st_req.rd && st_req.wr)) else $error("stack read and write together");
endmodule

bind bxc_exec bxc_exec_chk chk_u (
   .clk(clk), .reset_n(reset_n), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
   .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .pm_req(pm_req),
   .pm_rdata(pm_rdata), .rf_req(rf_req), .rf_rdata(rf_rdata), .st_req(st_req),
   .st_rdata(st_rdata), .busy(busy));

// ---- bxc_mem_model.sv ----
`timescale 1ns/10ps
module bxc_mem_model
   import bxc_pkg::*;
(
   input wire logic       clk,
   input wire bxc_mem_t   pm_req,
   output logic     [7:0] pm_rdata,
   input wire bxc_mem_t   rf_req,
   output logic     [7:0] rf_rdata,
   input wire bxc_mem_t   st_req,
   output logic     [7:0] st_rdata
);
   logic [7:0] pm [0:65535]; // program bytes, loaded by the bench
   logic [7:0] rf [0:255];   // register file page
   logic [7:0] st [0:65535]; // stack memory

   // unused cells read as zero, so fall-through code is a run of no-ops
   initial begin
      pm_rdata = 8'h00;
      rf_rdata = 8'h00;
      st_rdata = 8'h00;
      for (int i = 0; i < 65536; i++) begin
         pm[i] = 8'h00;
         st[i] = 8'h00;
         if (i < 256) rf[i] = 8'h00;
      end
   end

   // data one cycle after a read; otherwise the bus toggles so stale data never matches
   always @(posedge clk) begin
      pm_rdata <= pm_req.rd ? pm[pm_req.addr] : ~pm_rdata;
      rf_rdata <= rf_req.rd ? rf[rf_req.addr[7:0]] : ~rf_rdata;
      st_rdata <= st_req.rd ? st[st_req.addr] : ~st_rdata;
      if (rf_req.wr) rf[rf_req.addr[7:0]] <= rf_req.wdata;
      if (st_req.wr) st[st_req.addr] <= st_req.wdata;
   end
endmodule

// ---- bxc_exec_tb.sv ----
`timescale 1ns/10ps
module bxc_exec_tb
   import bxc_pkg::*;
;
   logic       clk = 1'b0;
   logic       reset_n = 1'b0;
   logic [7:0] sw_addr = 8'h00;
   logic [7:0] sw_wdata = 8'h00;
   logic       sw_wr = 1'b0;
   logic       sw_rd = 1'b0;
   logic [7:0] sw_rdata, pm_rdata, rf_rdata, st_rdata, rd_v;
   bxc_mem_t   pm_req, rf_req, st_req;
   logic       busy;
   int         miscompares = 0;
   int         tests_run = 0;
   int         cyc = 0;
   int         gap;          // cycles between two opcode fetches
   int         fetch_at [logic [15:0]]; // cycle of last program read per address

   bxc_exec dut_u (.clk(clk), .reset_n(reset_n), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
      .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .pm_req(pm_req),
      .pm_rdata(pm_rdata), .rf_req(rf_req), .rf_rdata(rf_rdata), .st_req(st_req),
      .st_rdata(st_rdata), .busy(busy));
   bxc_mem_model mem_u (.clk(clk), .pm_req(pm_req), .pm_rdata(pm_rdata), .rf_req(rf_req),
      .rf_rdata(rf_rdata), .st_req(st_req), .st_rdata(st_rdata));

   always #50 clk = ~clk;

   // timestamp program reads to measure instruction lengths
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (pm_req.rd === 1'b1) fetch_at[pm_req.addr] = cyc;
   end

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got %h want %h", $time, got, exp);
      end
   endtask

   // one-cycle strobes; each task starts on a fresh edge, so no double drive
   task automatic sw_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge clk);
      sw_wr <= 1'b0;
   endtask

   task automatic sw_read(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge clk);
      sw_rd <= 1'b0;
      #1 d = sw_rdata;
   endtask

   task automatic seg(input logic [15:0] a, input logic [111:0] b, input int n);
      for (int i = 0; i < n; i++) mem_u.pm[a + 16'(i)] = b[8*(n-1-i) +: 8];
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // reset values and unmapped address, as {addr, expected}
   logic [15:0] rst_tab [8] = '{16'hd500, 16'hd6c0, 16'hd800, 16'hd900, 16'hd200, 16'h1000,
                                16'hd000, 16'hd100};
   // register file results, as {addr, expected}; c0 is a bit_exclusive_or_op source and must not move
   logic [15:0] rf_tab [7] = '{16'hc106, 16'h0187, 16'h0500, 16'h0608, 16'h0800, 16'h1005,
                               16'hc001};
   // stack contents after three calls, as {addr, expected}
   logic [23:0] st_tab [6] = '{24'h01ff0e, 24'h01fe01, 24'h01fd02, 24'h01fc03,
                               24'h01fb02, 24'h01fa04};
   // {opcode address, next opcode address, cycles}
   logic [39:0] tm_tab [10] = '{40'h0100_0103_06, 40'h0103_0106_06, 40'h0106_0107_04,
      40'h0107_0109_04, 40'h0109_010b_04, 40'h010b_0300_0e, 40'h0300_0400_0e,
      40'h0400_0500_0c, 40'h0500_0402_0a, 40'h0402_0405_06};

   // main sequence
   initial begin
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      foreach (rst_tab[i]) begin
         sw_read(rst_tab[i][15:8], rd_v);
         check({8'h00, rd_v}, {8'h00, rst_tab[i][7:0]});
      end
      $display("test reset done");
      // bit_exclusive_or_op into r1, bit_exclusive_or_op into 01 bit 2 from r0, ccf, clr and indirect clr, three calls, return,
      // then bit_exclusive_or_op into 01 bit 7 from r0; both form-1 sources carry a one so bits flip
      seg(16'h0100, 112'h271201_270501_ef_b005_b106_f60300, 14);
      seg(16'h0300, 112'hd440, 2);
      seg(16'h0040, 112'h0400, 2);
      seg(16'h0400, 112'hf410, 2);
      seg(16'h0500, 112'haf, 1);
      seg(16'h0402, 112'h270f01, 3);
      mem_u.rf[8'hc0] = 8'h01;
      mem_u.rf[8'hc1] = 8'h07;
      mem_u.rf[8'h01] = 8'h03;
      mem_u.rf[8'h05] = 8'h55;
      mem_u.rf[8'h06] = 8'h08;
      mem_u.rf[8'h08] = 8'h5e;
      mem_u.rf[8'h10] = 8'h05;
      mem_u.rf[8'h11] = 8'h00;
      sw_write(OFF_FLAGS, 8'hac);
      sw_write(OFF_SPH, 8'h02);
      sw_write(OFF_SPL, 8'h00);
      sw_write(OFF_PCH, 8'h01);
      sw_write(OFF_PCL, 8'h00);
      sw_write(OFF_CTRL, 8'h01);
      repeat (150) @(posedge clk);
      sw_write(OFF_CTRL, 8'h00);
      for (int i = 0; i < 20 && busy !== 1'b0; i++) @(posedge clk);
      // sequencer stops after the current instruction
      check({15'h0, busy}, 16'h0000);
      foreach (rf_tab[i]) begin
         // results in registers
         check({8'h00, mem_u.rf[rf_tab[i][15:8]]},
               {8'h00, rf_tab[i][7:0]});
      end
      foreach (st_tab[i]) begin
         // pushed return bytes
         check({8'h00, mem_u.st[st_tab[i][23:8]]}, {8'h00, st_tab[i][7:0]});
      end
      foreach (tm_tab[i]) begin
         // next opcode fetched after exactly the instruction's cycles
         gap = fetch_at[tm_tab[i][23:8]] - fetch_at[tm_tab[i][39:24]];
         check(16'(gap), {8'h00, tm_tab[i][7:0]});
      end
      $display("test program done");
      sw_read(OFF_FLAGS, rd_v);
      // flags, overflow masked as undefined
      check({8'h00, rd_v & 8'hef}, 16'h000c);
      sw_read(OFF_SPH, rd_v);
      // stack pointer after return
      check({8'h00, rd_v}, 16'h0001);
      sw_read(OFF_SPL, rd_v);
      // stack pointer low byte
      check({8'h00, rd_v}, 16'h00fc);
      $display("test state done");
      close_out();
   end

   // watchdog sized well past the expected run of about two hundred cycles
   initial begin
      repeat (3000) @(posedge clk);
      miscompares++;
      close_out();
   end
endmodule
